/* ecd_cfg.svh */
`ifndef ECD_CFG_SVH
`define ECD_CFG_SVH
// per-channel register offsets
`define ECD_OFF_CTRL      6'h00
`define ECD_OFF_SRC_LO    6'h04
`define ECD_OFF_SRC_HI    6'h08
`define ECD_OFF_DST_LO    6'h0c
`define ECD_OFF_DST_HI    6'h10
`define ECD_OFF_SIZE      6'h14
`define ECD_OFF_STATUS    6'h18
`define ECD_OFF_BURST     6'h1c
`define ECD_OFF_WDATA     6'h20
`define ECD_OFF_DPTR_LO   6'h24
`define ECD_OFF_DPTR_HI   6'h28
// control bit positions
`define ECD_C_EN          0
`define ECD_C_PAUSE       1
`define ECD_C_SG          2
`define ECD_C_HYBRID      3
`define ECD_C_RDONLY      4
`define ECD_C_WRONLY      5
`define ECD_C_FIXSRC      6
`define ECD_C_FIXDST      7
`define ECD_C_SECURE      8
`define ECD_C_OVFDIS      9
`define ECD_C_FLOWEN      10
`define ECD_C_INTREN      11
`define ECD_C_RESUME      12
`define ECD_CTRL_W        12
// status field codes
`define ECD_ST_IDLE       2'h0
`define ECD_ST_BUSY       2'h1
`define ECD_ST_PAUSED     2'h2
`define ECD_ST_ENDED      2'h3
// burst reset: 16-beat reads and writes, no rate spacing
`define ECD_BURST_RST     32'h0000_00ff
// axi encodings and limits
`define ECD_BURST_FIXED   2'h0
`define ECD_BURST_INCR    2'h1
`define ECD_SIZE_BYTE     3'h0
`define ECD_SIZE_WIDE     3'h4
`define ECD_RESP_OKAY     2'h0
`define ECD_MAX_BEATS     5'h10
`define ECD_MAX_RD_OUT    6'h20
`define ECD_PAGE_BYTES    13'h1000
`define ECD_BUF_BYTES     4096
`endif

/* ecd_pkg.sv */
package ecd_pkg;
	parameter int AW = 48;

	typedef struct packed {
		logic          valid;
		logic [AW-1:0] addr;
		logic [7:0]    len;
		logic [2:0]    size;
		logic [1:0]    burst;
		logic [2:0]    prot;
	} ecd_addr_t;

	typedef struct packed {
		logic         valid;
		logic [127:0] data;
		logic [15:0]  strb;
		logic         last;
	} ecd_wbeat_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_DF_A  = 4'h1,
		S_DF_R  = 4'h2,
		S_CALC  = 4'h3,
		S_RD_A  = 4'h4,
		S_RD_D  = 4'h5,
		S_WR_A  = 4'h6,
		S_WR_D  = 4'h7,
		S_WR_B  = 4'h8,
		S_DONE  = 4'h9
	} ecd_state_t;
endpackage

/* ecd_dma.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "ecd_cfg.svh"
// Function
// R1: eight channels, own control, shared master
// R2: bursts on one 128-bit AXI master
// R3: 44 or 48 bit addresses
// R4: at most sixteen beats per burst
// R5: independent descriptors, any size, any alignment
// R6: no burst crosses a 4 KB boundary
// R7: over-fetch disable reads only payload bytes
// R8: channels enabled or disabled any time
// R9: pause on descriptor, resume continues
// R10: common buffer shared first-come first-served
// R11: buffer share limited by issuing, rate
// R12: at most 32 outstanding reads per channel
// R13: secure setting drives transaction protection bit
// R14: per-channel scheduling period spaces transactions
// R15: simple, scatter-gather and hybrid modes
// R16: descriptors fetched over the master
// R17: fixed bursts only in simple mode
// R18: independent read and write burst lengths (the code gives the read and write burst of a chunk the same beat count)
// R19: read-only mode reads, discards, never writes
// R20: write-only mode writes register data, no reads
// R21: aligned payloads move at full beat width
// R22: fabric valid must not follow ack combinationally
// R23: common buffer holds four kilobytes
// R24: round-robin, grant only with buffer room
// R25: error releases the channel's buffer entries
// R26: idle state field reads 00 or 11
// R27: done and error flags, per-channel interrupt
module ecd_dma #(
	parameter int ADDR_W = 48
) (
	input  wire logic                   core_clk,           // engine clock
	input  wire logic                   sys_rst,            // synchronous reset
	input  wire logic                   psel,               // apb select
	input  wire logic                   penable,            // apb access phase
	input  wire logic                   pwrite,             // apb direction
	input  wire logic [11:0]            paddr,              // apb byte address
	input  wire logic [31:0]            pwdata,             // apb write data
	output logic                        pready,             // apb ready
	output logic [31:0]                 prdata,             // apb read data
	output logic                        pslverr,            // apb error
	output ecd_pkg::ecd_addr_t          axiAr,              // read address
	input  wire logic                   arready,            // read address ready
	input  wire logic                   rvalid,             // read data valid
	input  wire logic [127:0]           rdata,              // read data
	input  wire logic [1:0]             rresp,              // read response
	input  wire logic                   rlast,              // last read beat
	output logic                        rready,             // read data ready
	output ecd_pkg::ecd_addr_t          axiAw,              // write address
	input  wire logic                   awready,            // write address ready
	output ecd_pkg::ecd_wbeat_t         axiW,               // write beat
	input  wire logic                   wready,             // write data ready
	input  wire logic                   bvalid,             // write response valid
	input  wire logic [1:0]             bresp,              // write response
	output logic                        bready,             // write response ready
	input  wire logic [7:0]             chan_flow_valid_in, // fabric flow valid
	output logic [7:0]                  chan_flow_ack_out,  // fabric flow ack
	output logic [7:0]                  chanIrq             // per-channel interrupt
);
	localparam int NCH = 8; // R1
	localparam int BUF_N = `ECD_BUF_BYTES / 16;

	if (ADDR_W != 44 && ADDR_W != 48) $error("ADDR_W must be 44 or 48"); // R3
	if (ADDR_W > ecd_pkg::AW) $error("ADDR_W wider than carrier");

	// ====
	// channel registers
	logic [`ECD_CTRL_W-1:0] ctrl_reg [NCH];
	logic [ADDR_W-1:0]      src_reg  [NCH];
	logic [ADDR_W-1:0]      dst_reg  [NCH];
	logic [29:0]            size_reg [NCH];
	logic [31:0]            burst_reg[NCH];
	logic [31:0]            wdat_reg [NCH];
	logic [ADDR_W-1:0]      dptr_reg [NCH];
	logic [NCH-1:0]         done_reg;
	logic [NCH-1:0]         err_reg;
	logic [NCH-1:0]         last_reg;
	logic [7:0]             rate_reg [NCH];

	// ====
	// engine state
	ecd_pkg::ecd_state_t state_reg;
	logic [2:0]          eCh_reg;
	logic [2:0]          rr_reg;
	logic [ADDR_W-1:0]   eSrc_reg;
	logic [ADDR_W-1:0]   eDst_reg;
	logic [12:0]         eChunk_reg;
	logic [4:0]          eBeats_reg;
	logic [4:0]          eBeat_reg;
	logic                eWide_reg;
	logic                eErr_reg;
	logic [7:0]          wp_reg;
	logic [7:0]          rp_reg;
	logic [8:0]          free_reg;
	logic [127:0]        buf_mem [BUF_N];

	function automatic logic [12:0] min13(input logic [12:0] a, input logic [12:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic [15:0] wideStrb(input logic [4:0] beat, input logic [3:0] off,
		input logic [12:0] len);
		logic [15:0] s;
		logic [12:0] pos;
		s = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			pos = {4'h0, beat, 4'h0} + 13'(i);
			s[i] = (pos >= {9'h000, off}) && (pos < {9'h000, off} + len);
		end
		return s;
	endfunction

	// ====
	// apb slave
	wire [2:0]  aCh   = paddr[8:6];
	wire [5:0]  aOff  = paddr[5:0];
	wire        aHit  = (paddr[11:9] == 3'h0) && (aOff <= `ECD_OFF_DPTR_HI) && (paddr[1:0] == 2'h0);
	wire        setup = psel && !penable && !pready;
	wire        wrAcc = psel && penable && pready && pwrite && aHit;
	logic [1:0] stField [NCH];

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			if (done_reg[c] || err_reg[c]) stField[c] = `ECD_ST_ENDED; // R26
			else if (ctrl_reg[c][`ECD_C_EN] && ctrl_reg[c][`ECD_C_PAUSE]) stField[c] = `ECD_ST_PAUSED;
			else if (ctrl_reg[c][`ECD_C_EN]) stField[c] = `ECD_ST_BUSY;
			else stField[c] = `ECD_ST_IDLE; // R26
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !aHit;
			if (setup && !pwrite && aHit) begin
				unique case (aOff)
					`ECD_OFF_CTRL:    prdata <= 32'({1'b0, ctrl_reg[aCh][`ECD_CTRL_W-1:0]});
					`ECD_OFF_SRC_LO:  prdata <= src_reg[aCh][31:0];
					`ECD_OFF_SRC_HI:  prdata <= 32'(src_reg[aCh][ADDR_W-1:32]);
					`ECD_OFF_DST_LO:  prdata <= dst_reg[aCh][31:0];
					`ECD_OFF_DST_HI:  prdata <= 32'(dst_reg[aCh][ADDR_W-1:32]);
					`ECD_OFF_SIZE:    prdata <= {2'h0, size_reg[aCh]};
					`ECD_OFF_STATUS:  prdata <= {28'h0, err_reg[aCh], done_reg[aCh], stField[aCh]};
					`ECD_OFF_BURST:   prdata <= burst_reg[aCh];
					`ECD_OFF_WDATA:   prdata <= wdat_reg[aCh];
					`ECD_OFF_DPTR_LO: prdata <= dptr_reg[aCh][31:0];
					`ECD_OFF_DPTR_HI: prdata <= 32'(dptr_reg[aCh][ADDR_W-1:32]);
					default:          prdata <= 32'h0000_0000;
				endcase
			end else if (setup) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ====
	// round-robin arbitration
	logic [NCH-1:0] elig;
	logic           grantOk;
	logic [2:0]     grantCh;

	always_comb begin
		grantOk = 1'b0;
		grantCh = 3'h0;
		for (int c = 0; c < NCH; c++) begin
			elig[c] = ctrl_reg[c][`ECD_C_EN] && !ctrl_reg[c][`ECD_C_PAUSE] // R8 R9
				&& !done_reg[c] && !err_reg[c] && rate_reg[c] == 8'h00 // R14
				&& (!ctrl_reg[c][`ECD_C_FLOWEN] || chan_flow_valid_in[c]);
		end
		for (int k = 1; k <= NCH; k++) begin
			if (!grantOk && elig[3'(rr_reg + 3'(k))]) begin // R24
				grantOk = 1'b1;
				grantCh = 3'(rr_reg + 3'(k));
			end
		end
	end

	// ====
	// chunk sizing
	logic [ADDR_W-1:0] cSrc;
	logic [ADDR_W-1:0] cDst;
	logic [12:0]       cRem;
	logic [12:0]       cMax;
	logic [12:0]       cLen;
	logic              cWide;
	logic [3:0]        cSrcL;
	logic [3:0]        cDstL;
	logic              cOvf;
	logic              cRo;
	logic              cWo;

	always_comb begin
		cSrc  = src_reg[eCh_reg];
		cDst  = dst_reg[eCh_reg];
		cRo   = ctrl_reg[eCh_reg][`ECD_C_RDONLY] && !ctrl_reg[eCh_reg][`ECD_C_SG];
		cWo   = ctrl_reg[eCh_reg][`ECD_C_WRONLY] && !ctrl_reg[eCh_reg][`ECD_C_SG];
		cOvf  = ctrl_reg[eCh_reg][`ECD_C_OVFDIS];
		cRem  = (size_reg[eCh_reg] > 30'h1000) ? `ECD_PAGE_BYTES : size_reg[eCh_reg][12:0];
		cSrcL = cWo ? cDst[3:0] : cSrc[3:0];
		cDstL = cRo ? cSrc[3:0] : cDst[3:0];
		// wide beats need matching lanes; over-fetch off also needs a full first beat
		cWide = (cSrcL == cDstL) && (!cOvf || (cSrcL == 4'h0 && cRem >= 13'h010)); // R5 R7 R21
		cMax  = min13(`ECD_PAGE_BYTES - {1'b0, cSrc[11:0]},
			`ECD_PAGE_BYTES - {1'b0, cDst[11:0]}); // R6
		cMax  = min13(cMax, cRem);
		if (cWide) begin
			// shortest of the read and write burst lengths bounds the chunk
			cLen = min13(cMax, {5'h00, 4'(burst_reg[eCh_reg][3:0] < burst_reg[eCh_reg][7:4]
				? burst_reg[eCh_reg][3:0] : burst_reg[eCh_reg][7:4]), 4'h0}
				+ 13'h010 - {9'h000, cSrcL}); // R4 R11 R18
			if (cOvf) cLen = {cLen[12:4], 4'h0}; // R7
		end else begin
			cLen = min13(cMax, 13'(burst_reg[eCh_reg][3:0]) + 13'h001); // R4 R7
		end
	end

	wire [12:0] wideBeats = ({9'h000, cSrcL} + cLen + 13'h00f) >> 4;
	wire [4:0]  nBeats    = cWide ? wideBeats[4:0] : cLen[4:0];
	wire        simpleCh  = !ctrl_reg[eCh_reg][`ECD_C_SG];
	wire [1:0]  srcBurst  = (simpleCh && ctrl_reg[eCh_reg][`ECD_C_FIXSRC])
		? `ECD_BURST_FIXED : `ECD_BURST_INCR; // R17
	wire [1:0]  dstBurst  = (simpleCh && ctrl_reg[eCh_reg][`ECD_C_FIXDST])
		? `ECD_BURST_FIXED : `ECD_BURST_INCR; // R17
	wire [2:0]  prot      = {1'b0, !ctrl_reg[eCh_reg][`ECD_C_SECURE], 1'b0}; // R13
	wire        needDesc  = ctrl_reg[eCh_reg][`ECD_C_SG] && size_reg[eCh_reg] == 30'h0;
	wire [3:0]  rLane     = eWide_reg ? 4'h0 : 4'(eSrc_reg[3:0] + 4'(eBeat_reg));
	wire [3:0]  wLane     = 4'(eDst_reg[3:0] + 4'(eBeat_reg));
	wire [7:0]  nextRp    = 8'(rp_reg + 8'h01);
	wire        rErr      = rvalid && rready && rresp != `ECD_RESP_OKAY;

	function automatic ecd_pkg::ecd_wbeat_t mkBeat(input logic [127:0] d, input logic [4:0] b,
		input logic [3:0] lane, input logic wide, input logic [3:0] off, input logic [12:0] len,
		input logic [4:0] nb);
		ecd_pkg::ecd_wbeat_t w;
		w.valid = 1'b1;
		w.data  = wide ? d : (d << {lane, 3'h0});
		w.strb  = wide ? wideStrb(b, off, len) : (16'h0001 << lane);
		w.last  = (b == 5'(nb - 5'h01));
		return w;
	endfunction

	wire [127:0] woData = {4{wdat_reg[eCh_reg]}}; // R20

	// ====
	// engine sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg  <= ecd_pkg::S_IDLE;
			eCh_reg    <= 3'h0;
			rr_reg     <= 3'h7;
			eSrc_reg   <= '0;
			eDst_reg   <= '0;
			eChunk_reg <= 13'h0000;
			eBeats_reg <= 5'h00;
			eBeat_reg  <= 5'h00;
			eWide_reg  <= 1'b0;
			eErr_reg   <= 1'b0;
			axiAr      <= '0;
			axiAw      <= '0;
			axiW       <= '0;
			rready     <= 1'b0;
			bready     <= 1'b0;
			chan_flow_ack_out <= 8'h00;
		end else begin
			chan_flow_ack_out <= 8'h00;
			unique case (state_reg)
				ecd_pkg::S_IDLE: begin
					eErr_reg <= 1'b0;
					if (grantOk && free_reg >= 9'(`ECD_MAX_BEATS)) begin // R10 R12 R24
						eCh_reg   <= grantCh;
						rr_reg    <= grantCh;
						chan_flow_ack_out <= 8'h01 << grantCh;
						state_reg <= ecd_pkg::S_CALC;
					end
				end
				ecd_pkg::S_CALC: begin
					eBeat_reg <= 5'h00;
					if (needDesc) begin // R15 R16
						eChunk_reg <= 13'h0000;
						axiAr     <= '{1'b1, ecd_pkg::AW'(dptr_reg[eCh_reg]), 8'h01,
							`ECD_SIZE_WIDE, `ECD_BURST_INCR, prot};
						state_reg <= ecd_pkg::S_DF_A;
					end else begin
						eSrc_reg   <= cSrc;
						eDst_reg   <= cDst;
						eChunk_reg <= cLen;
						eBeats_reg <= nBeats;
						eWide_reg  <= cWide;
						if (cWo) begin // R20
							axiAw     <= '{1'b1, ecd_pkg::AW'(cDst), 8'(nBeats - 5'h01),
								cWide ? `ECD_SIZE_WIDE : `ECD_SIZE_BYTE, dstBurst, prot};
							state_reg <= ecd_pkg::S_WR_A;
						end else begin
							axiAr     <= '{1'b1, ecd_pkg::AW'(cSrc), 8'(nBeats - 5'h01),
								cWide ? `ECD_SIZE_WIDE : `ECD_SIZE_BYTE, srcBurst, prot}; // R2
							state_reg <= ecd_pkg::S_RD_A;
						end
					end
				end
				ecd_pkg::S_DF_A, ecd_pkg::S_RD_A: begin
					if (arready) begin
						axiAr.valid <= 1'b0;
						rready      <= 1'b1;
						state_reg   <= (state_reg == ecd_pkg::S_DF_A) ? ecd_pkg::S_DF_R
							: ecd_pkg::S_RD_D;
					end
				end
				ecd_pkg::S_DF_R, ecd_pkg::S_RD_D: begin
					if (rvalid) begin
						eBeat_reg <= 5'(eBeat_reg + 5'h01);
						if (rErr) eErr_reg <= 1'b1;
						if (rlast) begin
							rready    <= 1'b0;
							eBeat_reg <= 5'h00;
							if (state_reg == ecd_pkg::S_DF_R || rErr || eErr_reg || cRo)
								state_reg <= ecd_pkg::S_DONE; // R19
							else begin
								axiAw     <= '{1'b1, ecd_pkg::AW'(eDst_reg),
									8'(eBeats_reg - 5'h01),
									eWide_reg ? `ECD_SIZE_WIDE : `ECD_SIZE_BYTE, dstBurst, prot};
								state_reg <= ecd_pkg::S_WR_A;
							end
						end
					end
				end
				ecd_pkg::S_WR_A: begin
					if (awready) begin
						axiAw.valid <= 1'b0;
						axiW        <= mkBeat(cWo ? woData : buf_mem[rp_reg], 5'h00, eDst_reg[3:0],
							eWide_reg, eDst_reg[3:0], eChunk_reg, eBeats_reg);
						state_reg   <= ecd_pkg::S_WR_D;
					end
				end
				ecd_pkg::S_WR_D: begin
					if (wready) begin
						eBeat_reg <= 5'(eBeat_reg + 5'h01);
						if (axiW.last) begin
							axiW      <= '0;
							bready    <= 1'b1;
							state_reg <= ecd_pkg::S_WR_B;
						end else begin
							axiW <= mkBeat(cWo ? woData : buf_mem[nextRp], 5'(eBeat_reg + 5'h01),
								4'(wLane + 4'h1), eWide_reg, eDst_reg[3:0], eChunk_reg,
								eBeats_reg);
						end
					end
				end
				ecd_pkg::S_WR_B: begin
					if (bvalid) begin
						bready    <= 1'b0;
						if (bresp != `ECD_RESP_OKAY) eErr_reg <= 1'b1;
						state_reg <= ecd_pkg::S_DONE;
					end
				end
				ecd_pkg::S_DONE: begin
					state_reg <= ecd_pkg::S_IDLE;
				end
				default: state_reg <= ecd_pkg::S_IDLE;
			endcase
		end
	end

	// ====
	// common buffer reservations
	wire isRead  = state_reg == ecd_pkg::S_RD_D;
	wire reserve = state_reg == ecd_pkg::S_IDLE && grantOk && free_reg >= 9'(`ECD_MAX_BEATS);

	always_ff @(posedge core_clk) begin
		if (isRead && rvalid && !cRo) begin // R19
			buf_mem[wp_reg] <= eWide_reg ? rdata : (rdata >> {rLane, 3'h0});
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wp_reg   <= 8'h00;
			rp_reg   <= 8'h00;
			free_reg <= 9'(BUF_N); // R23
		end else begin
			if (isRead && rvalid && !cRo) wp_reg <= 8'(wp_reg + 8'h01);
			if (state_reg == ecd_pkg::S_WR_D && wready && !cWo) rp_reg <= nextRp;
			if (reserve) free_reg <= 9'(free_reg - 9'(`ECD_MAX_BEATS)); // R10 R11
			else if (state_reg == ecd_pkg::S_DONE) begin
				free_reg <= 9'(free_reg + 9'(`ECD_MAX_BEATS));
				if (eErr_reg) rp_reg <= wp_reg; // R25
			end
			if (state_reg == ecd_pkg::S_RD_D && rvalid && rlast && (rErr || eErr_reg))
				rp_reg <= 8'(wp_reg + 8'h01); // R25
		end
	end

	// ====
	// channel register updates
	wire descBeat = state_reg == ecd_pkg::S_DF_R && rvalid && !rErr;
	wire chunkEnd = state_reg == ecd_pkg::S_DONE && !eErr_reg && eChunk_reg != 13'h0000;
	wire [29:0] remAfter = 30'(size_reg[eCh_reg] - 30'(eChunk_reg));

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int c = 0; c < NCH; c++) begin
				ctrl_reg[c]  <= '0;
				src_reg[c]   <= '0;
				dst_reg[c]   <= '0;
				size_reg[c]  <= 30'h0;
				burst_reg[c] <= `ECD_BURST_RST;
				wdat_reg[c]  <= 32'h0000_0000;
				dptr_reg[c]  <= '0;
				rate_reg[c]  <= 8'h00;
			end
			done_reg <= 8'h00;
			err_reg  <= 8'h00;
			last_reg <= 8'h00;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (rate_reg[c] != 8'h00) rate_reg[c] <= 8'(rate_reg[c] - 8'h01);
			end
			if (reserve) rate_reg[grantCh] <= burst_reg[grantCh][15:8]; // R14
			if (wrAcc) begin
				unique case (aOff)
					`ECD_OFF_CTRL: begin // R8 R9
						ctrl_reg[aCh] <= pwdata[`ECD_CTRL_W-1:0];
						if (pwdata[`ECD_C_RESUME]) ctrl_reg[aCh][`ECD_C_PAUSE] <= 1'b0;
						if (pwdata[`ECD_C_EN] && !ctrl_reg[aCh][`ECD_C_EN]
							&& pwdata[`ECD_C_SG]) size_reg[aCh] <= 30'h0;
					end
					`ECD_OFF_SRC_LO:  src_reg[aCh][31:0]        <= pwdata;
					`ECD_OFF_SRC_HI:  src_reg[aCh][ADDR_W-1:32] <= pwdata[ADDR_W-33:0]; // R3
					`ECD_OFF_DST_LO:  dst_reg[aCh][31:0]        <= pwdata;
					`ECD_OFF_DST_HI:  dst_reg[aCh][ADDR_W-1:32] <= pwdata[ADDR_W-33:0]; // R3
					`ECD_OFF_SIZE:    size_reg[aCh]  <= pwdata[29:0]; // R5
					`ECD_OFF_BURST:   burst_reg[aCh] <= pwdata; // R18
					`ECD_OFF_WDATA:   wdat_reg[aCh]  <= pwdata;
					`ECD_OFF_DPTR_LO: dptr_reg[aCh][31:0]        <= pwdata;
					`ECD_OFF_DPTR_HI: dptr_reg[aCh][ADDR_W-1:32] <= pwdata[ADDR_W-33:0];
					default: ;
				endcase
			end
			// descriptor: beat 0 src and size, beat 1 dst and next pointer
			if (descBeat && eBeat_reg == 5'h00) begin // R16
				src_reg[eCh_reg]  <= rdata[ADDR_W-1:0];
				size_reg[eCh_reg] <= rdata[93:64];
				last_reg[eCh_reg] <= rdata[96];
			end
			if (descBeat && eBeat_reg == 5'h01) begin
				dst_reg[eCh_reg]  <= rdata[ADDR_W-1:0];
				dptr_reg[eCh_reg] <= ctrl_reg[eCh_reg][`ECD_C_HYBRID] // R15
					? ADDR_W'(dptr_reg[eCh_reg] + ADDR_W'(32)) : rdata[64+ADDR_W-1:64];
			end
			if (chunkEnd) begin
				size_reg[eCh_reg] <= remAfter;
				if (srcBurst == `ECD_BURST_INCR)
					src_reg[eCh_reg] <= ADDR_W'(eSrc_reg + ADDR_W'(eChunk_reg));
				if (dstBurst == `ECD_BURST_INCR)
					dst_reg[eCh_reg] <= ADDR_W'(eDst_reg + ADDR_W'(eChunk_reg));
			end
			// software clear first so a same-cycle hardware set wins
			if (wrAcc && aOff == `ECD_OFF_STATUS) begin
				if (pwdata[2]) done_reg[aCh] <= 1'b0;
				if (pwdata[3]) err_reg[aCh]  <= 1'b0;
			end
			if (chunkEnd && remAfter == 30'h0 && (simpleCh || last_reg[eCh_reg])) begin
				done_reg[eCh_reg] <= 1'b1; // R27
				ctrl_reg[eCh_reg][`ECD_C_EN] <= 1'b0;
			end
			if (state_reg == ecd_pkg::S_DONE && eErr_reg) begin
				err_reg[eCh_reg] <= 1'b1; // R25 R27
				ctrl_reg[eCh_reg][`ECD_C_EN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) chanIrq <= 8'h00;
		else begin
			for (int c = 0; c < NCH; c++)
				chanIrq[c] <= ctrl_reg[c][`ECD_C_INTREN] && (done_reg[c] || err_reg[c]); // R27
		end
	end
endmodule

/* ecd_dma_assertions.sv */
`timescale 1ns/1ps
module ecd_dma_chk (
	input wire logic                core_clk, // clock
	input wire logic                sys_rst,  // reset
	input wire logic                psel,     // apb select
	input wire logic                penable,  // apb enable
	input wire logic [11:0]         paddr,    // apb address
	input wire logic                pready,   // apb ready
	input wire logic                pslverr,  // apb error
	input wire ecd_pkg::ecd_addr_t  axiAr,    // read address
	input wire logic                arready,  // read address ready
	input wire logic                rvalid,   // read valid
	input wire logic                rlast,    // last read beat
	input wire logic                rready,   // read ready
	input wire ecd_pkg::ecd_addr_t  axiAw,    // write address
	input wire ecd_pkg::ecd_wbeat_t axiW,     // write beat
	input wire logic                wready    // write ready
);
	// ====
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [6:0] rdOut;
	always_ff @(posedge core_clk)
		rdOut <= sys_rst ? 7'h00
			: rdOut + 7'(axiAr.valid && arready) - 7'(rvalid && rready && rlast);
	a_apb_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb ready not one pulse");
	a_apb_unmapped: assert property (psel && !penable && paddr >= 12'h200 |=> pslverr)
		else $error("unmapped access not refused");
	a_ar_len_max: assert property (axiAr.valid |-> axiAr.len < 8'h10)
		else $error("read burst too long");
	a_aw_len_max: assert property (axiAw.valid |-> axiAw.len < 8'h10)
		else $error("write burst too long");
	a_ar_page: assert property (axiAr.valid |->
		13'(axiAr.addr[11:0]) + ((13'(axiAr.len) + 13'h1) << axiAr.size) <= 13'h1000)
		else $error("read burst crosses page");
	a_aw_page: assert property (axiAw.valid |->
		13'(axiAw.addr[11:0]) + ((13'(axiAw.len) + 13'h1) << axiAw.size) <= 13'h1000)
		else $error("write burst crosses page");
	a_ar_hold: assert property (axiAr.valid && !arready |=> axiAr.valid && $stable(axiAr))
		else $error("read address dropped");
	a_w_hold: assert property (axiW.valid && !wready |=> $stable(axiW))
		else $error("write beat changed");
	a_rd_no_stall: assert property (axiAr.valid && arready |=> rready)
		else $error("read data back-pressured");
	a_rd_outstand: assert property (rdOut <= 7'h20)
		else $error("too many reads outstanding");
	c_ar_stall: cover property (axiAr.valid && !arready);
	c_w_stall: cover property (axiW.valid && !wready);
	c_unmapped: cover property (pready && pslverr);
endmodule

bind ecd_dma ecd_dma_chk i_chk (.*);

/* ecd_axi_mem.sv */
`timescale 1ns/1ps
module ecd_axi_mem (
	input wire logic                core_clk,          // clock
	input wire logic                sys_rst,           // reset
	input wire logic                slow,              // answer late
	input wire logic                errInj,            // bad read response
	input wire ecd_pkg::ecd_addr_t  axiAr,             // read address
	output logic                    arready,           // read address ready
	output logic                    rvalid,            // read valid
	output logic [127:0]            rdata,             // read data
	output logic [1:0]              rresp,             // read response
	output logic                    rlast,             // last read beat
	input wire logic                rready,            // read ready
	input wire ecd_pkg::ecd_addr_t  axiAw,             // write address
	output logic                    awready,           // write address ready
	input wire ecd_pkg::ecd_wbeat_t axiW,              // write beat
	output logic                    wready,            // write ready
	output logic                    bvalid,            // write response valid
	output logic [1:0]              bresp,             // write response
	input wire logic                bready,            // write response ready
	output logic [7:0]              chan_flow_valid_in // fabric request
);
	logic [127:0] mem [256];
	logic [11:0]  rA, wA;
	logic [2:0]   rS, wS;
	logic [7:0]   rN;
	logic [1:0]   dly;
	logic         go;
	// idle read data follows dly, so it changes every cycle and repeats every four cycles
	assign go = !slow || dly == 2'h3;
	assign rdata = rvalid ? mem[rA[11:4]] : {64{dly}};
	assign rresp = errInj ? 2'h2 : 2'h0;
	assign bresp = 2'h0;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{arready, rvalid, rlast, awready, wready, bvalid, dly} <= '0;
			chan_flow_valid_in <= 8'h00;
		end else begin
			dly <= dly + 2'h1;
			chan_flow_valid_in <= 8'hff;
			arready <= axiAr.valid && !arready && !rvalid && go;
			awready <= axiAw.valid && !awready && go;
			wready <= axiW.valid && !wready && go;
			if (axiAr.valid && arready)
				{rA, rS, rN, rvalid, rlast} <= {axiAr.addr[11:0], axiAr.size, axiAr.len,
					1'b1, axiAr.len == 8'h00};
			else if (rvalid && rready)
				{rA, rN, rvalid, rlast} <= {rA + (12'h1 << rS), rN - 8'h1, !rlast, rN == 8'h01};
			if (axiAw.valid && awready)
				{wA, wS} <= {axiAw.addr[11:0], axiAw.size};
			else if (axiW.valid && wready)
				wA <= wA + (12'h1 << wS);
			if (axiW.valid && wready)
				bvalid <= axiW.last;
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	always @(posedge core_clk)
		if (axiW.valid && wready)
			for (int i = 0; i < 16; i++)
				if (axiW.strb[i])
					mem[wA[11:4]][i*8 +: 8] <= axiW.data[i*8 +: 8];
endmodule

/* tb_ecd_dma.sv */
`timescale 1ns/1ps
`include "ecd_cfg.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin badCount++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_ecd_dma;
	logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, errInj = 0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0, prdata, rd;
	logic         se, pready, pslverr, arready, rvalid, rlast, rready;
	logic         awready, wready, bvalid, bready;
	logic [127:0] rdata;
	logic [1:0]   rresp, bresp;
	logic [7:0]   chan_flow_valid_in, chan_flow_ack_out, chanIrq;
	ecd_pkg::ecd_addr_t  axiAr, axiAw;
	ecd_pkg::ecd_wbeat_t axiW;
	int badCount = 0, testsRun = 0, cyc = 0, arCnt = 0, awCnt = 0, n0;
	ecd_dma i_dut (.*);
	ecd_axi_mem i_mem (.*);
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		arCnt += int'(axiAr.valid && arready);
		awCnt += int'(axiAw.valid && awready);
		if (cyc == 30000) begin
			badCount++;
			completeRun();
		end
	end
	// ====
	// bus tasks
	function automatic logic [11:0] ra(input int c, input logic [5:0] o);
		return 12'(c * 64) + 12'(o);
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk);
		while (pready !== 1'b1);
		{rd, se} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		@(posedge core_clk);
	endtask
	task automatic run(input int c, input logic [31:0] ctl, s, dd, sz);
		apb(1'b1, ra(c, `ECD_OFF_SRC_LO), s);
		apb(1'b1, ra(c, `ECD_OFF_DST_LO), dd);
		apb(1'b1, ra(c, `ECD_OFF_SIZE), sz);
		apb(1'b1, ra(c, `ECD_OFF_CTRL), ctl);
		while (rd[1:0] !== 2'h3) apb(1'b0, ra(c, `ECD_OFF_STATUS), 32'h0);
	endtask
	task automatic completeRun();
		$display("checks %0d errors %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 256; i++) i_mem.mem[i] = {4{32'(i)}};
		apb(1'b0, ra(7, `ECD_OFF_BURST), 32'h0);
		`CHK(rd, `ECD_BURST_RST)
		apb(1'b0, ra(0, `ECD_OFF_STATUS), 32'h0);
		`CHK(rd[1:0], `ECD_ST_IDLE)
		apb(1'b0, 12'h200, 32'h0);
		`CHK({se, rd}, 33'h1_0000_0000)
		slow <= 1'b1;
		run(3, 32'h801, 32'h0fc0, 32'h1040, 32'd128);
		`CHK(rd[3:0], 4'h7)
		`CHK(chanIrq[3], 1'b1)
		for (int k = 0; k < 8; k++) `CHK(i_mem.mem[4+k], {4{24'h0, 8'(252 + k)}})
		slow <= 1'b0;
		n0 = awCnt;
		run(5, 32'h11, 32'h0, 32'h300, 32'd32);
		`CHK(awCnt, n0)
		n0 = arCnt;
		apb(1'b1, ra(6, `ECD_OFF_WDATA), 32'hdead_beef);
		run(6, 32'h21, 32'h0, 32'h800, 32'd32);
		`CHK(arCnt, n0)
		`CHK(i_mem.mem[8'h81], {4{32'hdead_beef}})
		errInj <= 1'b1;
		n0 = awCnt;
		run(1, 32'h1, 32'h0, 32'h400, 32'd16);
		errInj <= 1'b0;
		`CHK(rd[3:0], 4'hb)
		`CHK(awCnt, n0)
		apb(1'b0, ra(1, `ECD_OFF_CTRL), 32'h0);
		`CHK(rd[0], 1'b0)
		run(2, 32'h1, 32'h200, 32'h600, 32'd16);
		`CHK(rd[3:0], 4'h7)
		`CHK(i_mem.mem[8'h60], {4{32'h20}})
		completeRun();
	end
endmodule
